// File: flash_host_pkg.sv
/*
 * Shared constants for the flash host controller: operation codes on the
 * user port, command bytes sent to the device, status bit positions and
 * bus timing counts.
 * Assumes a 40 MHz ref_clk and a byte-wide flash with a 20-bit address.
 */
package flash_host_pkg;
	localparam int ADDR_W = 20; // 1M x 8 array
	localparam int DATA_W = 8;
	localparam int BLOCK_LSB = 16; // 64 Kbyte blocks
	// user operations
	localparam logic [3:0] OP_READ = 4'h0; // read in current mode
	localparam logic [3:0] OP_READ_ARRAY = 4'h1;
	localparam logic [3:0] OP_IDENT = 4'h2;
	localparam logic [3:0] OP_STATUS = 4'h3;
	localparam logic [3:0] OP_CLEAR = 4'h4;
	localparam logic [3:0] OP_ERASE = 4'h5;
	localparam logic [3:0] OP_SUSPEND = 4'h6;
	localparam logic [3:0] OP_RESUME = 4'h7;
	localparam logic [3:0] OP_WRITE = 4'h8;
	// command bytes written to the command_port
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_IDENT = 8'h90;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR = 8'h50;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0; // erase confirm and resume
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_WRITE_SETUP = 8'h40; // 10H also accepted
	// identifier addresses
	localparam logic [19:0] IDENT_MFR_ADDR = 20'h00000;
	localparam logic [19:0] IDENT_DEV_ADDR = 20'h00001;
	// status byte bit positions
	localparam int SR_READY = 7;
	localparam int SR_SUSPEND = 6;
	localparam int SR_ERASE_ERR = 5;
	localparam int SR_WRITE_ERR = 4;
	localparam int SR_SUPPLY = 3; // supply_fault_bit
	// timing, figures in ns and derived cycle counts
	localparam int CLK_NS = 25;
	localparam int SETUP_NS = 50; // address to strobe
	localparam int STROBE_NS = 100; // strobe low width
	localparam int HOLD_NS = 25; // strobe high before next cycle
	localparam int SETTLE_NS = 100; // write end to ready_busy low
	localparam int WAKE_NS = 1000; // power-down exit to first write
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
	// host view of the device read mode
	typedef enum logic [1:0] {
		MODE_ARRAY = 2'b00,
		MODE_IDENT = 2'b01,
		MODE_STATUS = 2'b11
	} read_mode_t;
endpackage : flash_host_pkg

// File: flash_bus_cycle.sv
/*
 * One asynchronous bus cycle on the flash pins: a write (address and
 * data latched by the device at the rising write strobe) or a read
 * (data sampled just before output enable rises).
 * Assumes start is only pulsed while done-to-start is idle.
 */
`timescale 1ns/1ps
module flash_bus_cycle (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic start, // one-cycle pulse
	input wire logic writeCycle, // 1 write, 0 read
	input wire logic [19:0] addrIn,
	input wire logic [7:0] dataIn,
	output logic done, // one-cycle pulse
	output logic [7:0] readData,
	output logic chipEnN,
	output logic outEnN,
	output logic wrEnN,
	output logic [19:0] addrOut,
	output logic [7:0] dqOut,
	output logic dqOe,
	input wire logic [7:0] dqIn
);
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_SETUP = 2'b01,
		PH_STROBE = 2'b11,
		PH_HOLD = 2'b10
	} phase_t;

	phase_t phase; // cycle phase
	logic [5:0] cnt; // cycles left in phase
	logic isWrite; // latched kind of cycle

	// phase sequencing; both strobes always return high, so every read
	// gets a fresh falling edge and a fresh status latch
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			phase <= PH_IDLE;
			cnt <= 6'h00;
			isWrite <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (phase)
				PH_IDLE: begin
					if (start) begin
						phase <= PH_SETUP;
						isWrite <= writeCycle;
						cnt <= 6'(flash_host_pkg::SETUP_CYC - 1);
					end
				end
				PH_SETUP: begin
					if (cnt == 6'h00) begin
						phase <= PH_STROBE;
						cnt <= 6'(flash_host_pkg::STROBE_CYC - 1);
					end else begin
						cnt <= cnt - 6'h01;
					end
				end
				PH_STROBE: begin
					if (cnt == 6'h00) begin
						phase <= PH_HOLD;
						cnt <= 6'(flash_host_pkg::HOLD_CYC - 1);
					end else begin
						cnt <= cnt - 6'h01;
					end
				end
				PH_HOLD: begin
					if (cnt == 6'h00) begin
						phase <= PH_IDLE;
						done <= 1'b1;
					end else begin
						cnt <= cnt - 6'h01;
					end
				end
				default: phase <= PH_IDLE;
			endcase
		end
	end

	// pin drive; address and data held steady over the whole cycle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			chipEnN <= 1'b1;
			outEnN <= 1'b1;
			wrEnN <= 1'b1;
			addrOut <= 20'h00000;
			dqOut <= 8'h00;
			dqOe <= 1'b0;
		end else if (phase == PH_IDLE && start) begin
			chipEnN <= 1'b0;
			addrOut <= addrIn;
			dqOut <= dataIn;
			dqOe <= writeCycle;
		end else if (phase == PH_SETUP && cnt == 6'h00) begin
			wrEnN <= ~isWrite;
			outEnN <= isWrite;
		end else if (phase == PH_STROBE && cnt == 6'h00) begin
			// write data latched by device on this rising edge
			wrEnN <= 1'b1;
			outEnN <= 1'b1;
		end else if (phase == PH_HOLD && cnt == 6'h00) begin
			chipEnN <= 1'b1;
			dqOe <= 1'b0;
		end
	end

	// read data sampled at end of output-enable low time
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			readData <= 8'h00;
		end else if (phase == PH_STROBE && cnt == 6'h00 && !isWrite) begin
			readData <= dqIn;
		end
	end
endmodule : flash_bus_cycle

// File: flash_host_ctrl.sv
/*
 * Host-side controller for a byte-wide command-driven flash: turns user
 * operations into command sequences on the device pins, tracks the
 * device read mode, busy and suspend state, and refuses sequences the
 * device would not accept.
 * Assumes the device pins connect directly and ready_busy_out is a
 * clean level synchronous to ref_clk.
 */
// Operation
// - identifier mode stays until new command
// - status latched on late strobe fall
// - clear supply fault before write/erase
// - 20H then D0H inside target block
// - suspended: only array read, 70H, D0H
// - 40H or 10H then address and data
// - no reserved command codes
`timescale 1ns/1ps
module flash_host_ctrl (
	input wire logic ref_clk,
	input wire logic srst,
	// user side
	input wire logic cmdValid,
	output logic cmdReady,
	input wire logic [3:0] cmdOp,
	input wire logic [19:0] cmdAddr,
	input wire logic [7:0] cmdData,
	input wire logic powerDownReq, // hold device in deep power-down
	output logic rspValid,
	output logic rspErr,
	output logic [7:0] rspData,
	output logic [7:0] statusByte,
	output logic devBusy,
	output logic devSuspended,
	output logic supplyFault,
	output logic [1:0] readMode,
	// device side
	output logic powerdown_reset_n,
	output logic chipEnN,
	output logic outEnN,
	output logic wrEnN,
	output logic [19:0] addrOut,
	output logic [7:0] dqOut,
	output logic dqOe,
	input wire logic [7:0] dqIn,
	input wire logic ready_busy_out
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WR1 = 3'b001,
		ST_WR2 = 3'b011,
		ST_RD = 3'b010,
		ST_RESP = 3'b110
	} seq_t;

	seq_t state; // sequencer state
	logic [3:0] op; // accepted operation
	logic [19:0] addr; // accepted address
	logic [7:0] data; // accepted write value
	logic busStart; // pulse to cycle engine
	logic busWrite;
	logic [19:0] busAddr;
	logic [7:0] busData;
	logic busDone;
	logic [7:0] busRead;
	flash_host_pkg::read_mode_t mode; // device read mode as tracked
	logic running; // erase or byte write in progress
	logic eraseRun; // the running operation is an erase
	logic suspendReq; // B0H sent, pause not yet seen
	logic [3:0] suspBlock; // block held in suspension
	logic [5:0] settle; // ignore ready_busy while it settles
	logic [5:0] wake; // power-down exit guard
	logic refuse; // current request not allowed
	logic [7:0] code; // first command byte for op
	logic sameBlock;

	assign cmdReady = (state == ST_IDLE);
	assign rspValid = (state == ST_RESP);
	assign devBusy = running && !devSuspended;
	assign readMode = mode;
	assign sameBlock = cmdAddr[19:16] == suspBlock;

	// command byte per op; 40H chosen for byte-write setup
	always_comb begin
		case (op)
			flash_host_pkg::OP_READ_ARRAY: code = flash_host_pkg::CMD_READ_ARRAY;
			flash_host_pkg::OP_IDENT: code = flash_host_pkg::CMD_IDENT;
			flash_host_pkg::OP_STATUS: code = flash_host_pkg::CMD_STATUS;
			flash_host_pkg::OP_CLEAR: code = flash_host_pkg::CMD_CLEAR;
			flash_host_pkg::OP_ERASE: code = flash_host_pkg::CMD_ERASE_SETUP;
			flash_host_pkg::OP_SUSPEND: code = flash_host_pkg::CMD_SUSPEND;
			flash_host_pkg::OP_RESUME: code = flash_host_pkg::CMD_CONFIRM;
			default: code = flash_host_pkg::CMD_WRITE_SETUP;
		endcase
	end

	// acceptance check against the device's command rules
	always_comb begin
		refuse = 1'b0;
		if (powerDownReq || !powerdown_reset_n || wake != 6'h00) begin
			refuse = 1'b1;
		end else if (cmdOp > flash_host_pkg::OP_WRITE) begin
			refuse = 1'b1; // reserved codes never sent
		end else if (devSuspended) begin
			// only array read off the held block, 70H, D0H
			case (cmdOp)
				flash_host_pkg::OP_READ:
					refuse = mode == flash_host_pkg::MODE_ARRAY && sameBlock;
				flash_host_pkg::OP_READ_ARRAY: refuse = 1'b0;
				flash_host_pkg::OP_STATUS: refuse = 1'b0;
				flash_host_pkg::OP_RESUME: refuse = 1'b0;
				default: refuse = 1'b1;
			endcase
		end else if (running) begin
			// read-array ignored while busy byte write takes only
			// 70H erase also takes B0H
			case (cmdOp)
				flash_host_pkg::OP_READ:
					refuse = mode != flash_host_pkg::MODE_STATUS;
				flash_host_pkg::OP_STATUS: refuse = 1'b0;
				flash_host_pkg::OP_SUSPEND: refuse = !eraseRun || suspendReq;
				default: refuse = 1'b1;
			endcase
		end else begin
			case (cmdOp)
				flash_host_pkg::OP_SUSPEND: refuse = 1'b1;
				flash_host_pkg::OP_RESUME: refuse = 1'b1;
				flash_host_pkg::OP_ERASE: refuse = supplyFault;
				flash_host_pkg::OP_WRITE: refuse = supplyFault;
				default: refuse = 1'b0; // any supply level
			endcase
		end
	end

	// operation sequencer
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= ST_IDLE;
			op <= flash_host_pkg::OP_READ;
			addr <= 20'h00000;
			data <= 8'h00;
			busStart <= 1'b0;
			busWrite <= 1'b0;
			busAddr <= 20'h00000;
			busData <= 8'h00;
			rspErr <= 1'b0;
			rspData <= 8'h00;
		end else begin
			busStart <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (cmdValid) begin
						op <= cmdOp;
						addr <= cmdAddr;
						data <= cmdData;
						rspErr <= refuse;
						rspData <= 8'h00;
						busAddr <= cmdAddr;
						if (refuse) begin
							state <= ST_RESP;
						end else if (cmdOp == flash_host_pkg::OP_READ) begin
							busStart <= 1'b1;
							busWrite <= 1'b0;
							state <= ST_RD;
						end else begin
							busStart <= 1'b1;
							busWrite <= 1'b1;
							busData <= 8'h00;
							state <= ST_WR1;
						end
					end
				end
				ST_WR1: begin
					if (busDone) begin
						if (op == flash_host_pkg::OP_ERASE) begin
							// confirm to the same block address
							busStart <= 1'b1;
							busData <= flash_host_pkg::CMD_CONFIRM;
							state <= ST_WR2;
						end else if (op == flash_host_pkg::OP_WRITE) begin
							busStart <= 1'b1; // address and value
							busData <= data;
							state <= ST_WR2;
						end else begin
							state <= ST_RESP;
						end
					end
				end
				ST_WR2: begin
					if (busDone) begin
						state <= ST_RESP;
					end
				end
				ST_RD: begin
					if (busDone) begin
						rspData <= busRead;
						state <= ST_RESP;
					end
				end
				ST_RESP: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// first write carries the command byte chosen above; the engine sees
	// busStart a cycle after the take, when the sequencer is already in
	// ST_WR1, so the command byte must be offered in that state
	logic [7:0] firstData;
	assign firstData = (state == ST_WR1) ? code : busData;

	// read-mode tracking of the device command decoder
	always_ff @(posedge ref_clk) begin
		if (srst || !powerdown_reset_n) begin
			mode <= flash_host_pkg::MODE_ARRAY;
		end else if (state == ST_WR1 && busDone) begin
			case (op)
				flash_host_pkg::OP_READ_ARRAY:
					mode <= flash_host_pkg::MODE_ARRAY;
				flash_host_pkg::OP_IDENT:
					mode <= flash_host_pkg::MODE_IDENT;
				flash_host_pkg::OP_CLEAR: mode <= mode;
				// 70H, B0H, D0H all leave reads on status
				default: mode <= flash_host_pkg::MODE_STATUS;
			endcase
		end
	end

	// run, suspend and settle tracking from commands sent and the ready_busy pin
	always_ff @(posedge ref_clk) begin
		if (srst || !powerdown_reset_n) begin
			running <= 1'b0;
			eraseRun <= 1'b0;
			suspendReq <= 1'b0;
			devSuspended <= 1'b0;
			suspBlock <= 4'h0;
			settle <= 6'h00;
		end else begin
			if (settle != 6'h00) begin
				settle <= settle - 6'h01;
			end
			if (state == ST_WR2 && busDone) begin
				running <= 1'b1; // erase or byte write started
				eraseRun <= op == flash_host_pkg::OP_ERASE;
				suspBlock <= addr[19:16];
				settle <= 6'(flash_host_pkg::SETTLE_CYC);
			end else if (state == ST_WR1 && busDone &&
					op == flash_host_pkg::OP_SUSPEND) begin
				suspendReq <= 1'b1;
			end else if (state == ST_WR1 && busDone &&
					op == flash_host_pkg::OP_RESUME) begin
				devSuspended <= 1'b0;
				settle <= 6'(flash_host_pkg::SETTLE_CYC);
			end else if (running && settle == 6'h00 && ready_busy_out) begin
				// pin high: paused if asked, else finished
				if (suspendReq) begin
					devSuspended <= 1'b1;
					suspendReq <= 1'b0;
				end else if (!devSuspended) begin
					running <= 1'b0;
				end
			end
		end
	end

	// captured status byte and sticky supply fault; set beats clear
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			statusByte <= 8'h80;
			supplyFault <= 1'b0;
		end else if (!powerdown_reset_n) begin
			statusByte <= 8'h80; // upper five bits 10000
			supplyFault <= 1'b0;
		end else if (state == ST_RD && busDone &&
				mode == flash_host_pkg::MODE_STATUS) begin
			statusByte <= {busRead[7:3], 3'b000}; // reserved bits zero
			// fault after low-supply erase must be cleared
			if (busRead[flash_host_pkg::SR_SUPPLY]) begin
				supplyFault <= 1'b1;
			end
		end else if (state == ST_WR1 && busDone &&
				op == flash_host_pkg::OP_CLEAR) begin
			// apart from srst and power-down, 50H is the only way to drop sticky errors
			statusByte[flash_host_pkg::SR_ERASE_ERR] <= 1'b0;
			statusByte[flash_host_pkg::SR_WRITE_ERR] <= 1'b0;
			statusByte[flash_host_pkg::SR_SUPPLY] <= 1'b0;
			supplyFault <= 1'b0;
		end
	end

	// power-down pin and wake guard before the first command write
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			powerdown_reset_n <= 1'b0;
			wake <= 6'h00;
		end else begin
			powerdown_reset_n <= !powerDownReq;
			if (!powerdown_reset_n) begin
				wake <= 6'(flash_host_pkg::WAKE_CYC);
			end else if (wake != 6'h00) begin
				wake <= wake - 6'h01;
			end
		end
	end

	flash_bus_cycle busEngine (
		.ref_clk(ref_clk),
		.srst(srst),
		.start(busStart),
		.writeCycle(busWrite),
		.addrIn(busAddr),
		.dataIn(firstData),
		.done(busDone),
		.readData(busRead),
		.chipEnN(chipEnN),
		.outEnN(outEnN),
		.wrEnN(wrEnN),
		.addrOut(addrOut),
		.dqOut(dqOut),
		.dqOe(dqOe),
		.dqIn(dqIn)
	);
endmodule : flash_host_ctrl

// File: flash_host_ctrl_sva.sv
/*
 * Concurrent checks on the host controller top-level ports.
 * Assumes one clock domain, ref_clk, with synchronous srst.
 */
`timescale 1ns/1ps
module flash_host_ctrl_sva (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic cmdValid,
	input wire logic cmdReady,
	input wire logic [3:0] cmdOp,
	input wire logic powerDownReq,
	input wire logic rspValid,
	input wire logic rspErr,
	input wire logic [7:0] statusByte,
	input wire logic devBusy,
	input wire logic devSuspended,
	input wire logic supplyFault,
	input wire logic [1:0] readMode,
	input wire logic powerdown_reset_n,
	input wire logic chipEnN,
	input wire logic outEnN,
	input wire logic wrEnN,
	input wire logic [19:0] addrOut,
	input wire logic [7:0] dqOut,
	input wire logic dqOe,
	input wire logic ready_busy_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// request accepted this edge
	wire take = cmdValid && cmdReady;
	a_strobe_excl: assert property (outEnN || wrEnN)
		else $error("read and write strobes low together");
	a_write_sel: assert property (!wrEnN |-> !chipEnN)
		else $error("write strobe without chip select");
	a_no_contend: assert property (!outEnN |-> !dqOe)
		else $error("driving data while device outputs");
	a_wr_width: assert property ($fell(wrEnN) |-> (!wrEnN) [*4] ##1 wrEnN)
		else $error("write strobe width wrong");
	a_wr_hold: assert property (!wrEnN && !$past(wrEnN) |->
		$stable(addrOut) && $stable(dqOut))
		else $error("address or data moved under write strobe");
	a_pd_pin: assert property (powerDownReq |=> !powerdown_reset_n)
		else $error("power-down request not on pin");
	a_busy_status: assert property (devBusy |-> readMode == 2'b11)
		else $error("busy device not in status mode");
	a_susp_ready: assert property ($rose(devSuspended) |->
		$past(ready_busy_out))
		else $error("suspend claimed before ready pin high");
	a_status_low: assert property (statusByte[2:0] == 3'b000)
		else $error("reserved status bits nonzero");
	a_fault_refuse: assert property (take && supplyFault &&
		(cmdOp == flash_host_pkg::OP_ERASE || cmdOp == flash_host_pkg::OP_WRITE)
		|-> ##1 rspValid && rspErr)
		else $error("write or erase sent with supply fault");
	a_resv_refuse: assert property (take && cmdOp > 4'h8 |->
		chipEnN [*2] ##0 rspValid && rspErr)
		else $error("reserved operation not refused");
	a_rsp_pulse: assert property (rspValid |=> !rspValid)
		else $error("response longer than one cycle");
	c_erase: cover property (take && cmdOp == flash_host_pkg::OP_ERASE);
	c_susp: cover property ($rose(devSuspended));
	c_fault: cover property ($rose(supplyFault));
endmodule : flash_host_ctrl_sva
bind flash_host_ctrl flash_host_ctrl_sva flash_host_ctrl_sva_inst (
	.ref_clk(ref_clk), .srst(srst), .cmdValid(cmdValid), .cmdReady(cmdReady),
	.cmdOp(cmdOp), .powerDownReq(powerDownReq), .rspValid(rspValid),
	.rspErr(rspErr), .statusByte(statusByte), .devBusy(devBusy),
	.devSuspended(devSuspended), .supplyFault(supplyFault),
	.readMode(readMode), .powerdown_reset_n(powerdown_reset_n),
	.chipEnN(chipEnN), .outEnN(outEnN), .wrEnN(wrEnN), .addrOut(addrOut),
	.dqOut(dqOut), .dqOe(dqOe), .ready_busy_out(ready_busy_out));

// File: flash_dev_model.sv
/*
 * Behavioural model of the byte-wide flash: command decoder, status
 * byte, identifier codes, array and a shortened write state machine.
 * Assumes the controller strobes are registers on ref_clk.
 */
`timescale 1ns/1ps
module flash_dev_model #(
	parameter int ERASE_CYC = 300, // shortened erase time
	parameter int WRITE_CYC = 80, // shortened write time
	parameter logic [7:0] MFR_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] DEV_ID = 8'hC3 // arbitrary value
) (
	input wire logic ref_clk,
	input wire logic vppHigh,
	input wire logic powerdown_reset_n,
	input wire logic chipEnN,
	input wire logic outEnN,
	input wire logic wrEnN,
	input wire logic [19:0] addrOut,
	input wire logic [7:0] dqOut,
	output logic [7:0] dqIn,
	output logic ready_busy_out
);
	logic [7:0] mem [0:1048575]; // whole array
	logic [1:0] mode; // 0 array, 1 ident, 2 status
	logic [1:0] pend; // 1 erase setup, 2 write setup
	logic eraseRun, susp, errE, errW, fltV, wl, rdPrev;
	logic [19:0] la;
	logic [7:0] ld, srLatch;
	int busyCnt, susCnt;
	function automatic logic [7:0] sr();
		return {!(busyCnt > 0 && !susp), susp, errE, errW, fltV, 3'b000};
	endfunction : sr
	// decode one latched command write
	task automatic exec(input logic [19:0] a, input logic [7:0] d);
		if (busyCnt > 0 && !susp) begin
			if (d == 8'h70) mode = 2;
			else if (d == 8'hB0 && eraseRun) susCnt = 6;
		end else if (susp) begin
			if (d == 8'hFF) mode = 0;
			else if (d == 8'h70) mode = 2;
			else if (d == 8'hD0) susp = 0;
			if (d == 8'hD0) mode = 2;
		end else if (pend != 0) begin
			mode = 2;
			if (pend == 1 && d != 8'hD0) {errE, errW} = 2'b11;
			else if (!vppHigh) fltV = 1;
			else if (pend == 2) begin
				mem[a] = d;
				busyCnt = WRITE_CYC;
				eraseRun = 0;
			end else begin
				for (int k = 0; k < 65536; k++) mem[{a[19:16], k[15:0]}] = 8'hFF;
				busyCnt = ERASE_CYC;
				eraseRun = 1;
			end
			pend = 0;
		end else case (d)
			8'hFF: mode = 0;
			8'h90: mode = 1;
			8'h70: mode = 2;
			8'h50: {errE, errW, fltV} = 3'b000;
			8'h20: pend = 1;
			8'h40, 8'h10: pend = 2;
			default: ; // reserved codes do nothing
		endcase
	endtask : exec
	initial begin
		for (int k = 0; k < 1048576; k++) mem[k] = 8'hFF;
		dqIn = 8'h00;
	end
	// strobes are sampled a clock late; the controller holds them long enough
	always @(posedge ref_clk) begin
		if (!powerdown_reset_n) begin
			{mode, pend, susp, eraseRun, wl, rdPrev} = 8'h00;
			{errE, errW, fltV, busyCnt, susCnt} = 0;
		end else begin
			if (busyCnt > 0 && !susp) busyCnt--;
			if (susCnt > 0) susCnt--;
			if (susCnt == 1) susp = 1;
			if (!wrEnN && !chipEnN) begin
				la = addrOut;
				ld = dqOut;
				wl = 1;
			end else if (wl) begin
				wl = 0;
				exec(la, ld);
			end
			if (!chipEnN && !outEnN && !rdPrev) srLatch = sr();
			rdPrev = !chipEnN && !outEnN;
		end
		ready_busy_out <= !(busyCnt > 0 && !susp);
		// released bus shows a changing pattern, never the last value
		if (rdPrev) dqIn <= mode == 2 ? srLatch :
			mode == 1 ? (addrOut[0] ? DEV_ID : MFR_ID) : mem[addrOut];
		else dqIn <= ~dqIn;
	end
endmodule : flash_dev_model

// File: flash_host_ctrl_test.sv
/*
 * Self-checking bench for the flash host controller with a device model.
 * Assumes the package and both modules are compiled first.
 */
`timescale 1ns/1ps
module flash_host_ctrl_test;
	logic ref_clk, srst, cmdValid, powerDownReq, vppHigh, rErr;
	logic [3:0] cmdOp;
	logic [19:0] cmdAddr, addrOut;
	logic [7:0] cmdData, rspData, statusByte, dqOut, dqIn, rDat;
	logic cmdReady, rspValid, rspErr, devBusy, devSuspended, supplyFault;
	logic [1:0] readMode;
	logic powerdown_reset_n, chipEnN, outEnN, wrEnN, dqOe, ready_busy_out;
	int error_cnt = 0;
	int checks_done = 0;
	localparam logic [7:0] MFR = 8'h5A; // arbitrary value
	localparam logic [7:0] DEV = 8'hC3; // arbitrary value
	flash_host_ctrl flash_host_ctrl_inst (.ref_clk(ref_clk), .srst(srst),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
		.cmdAddr(cmdAddr), .cmdData(cmdData), .powerDownReq(powerDownReq),
		.rspValid(rspValid), .rspErr(rspErr), .rspData(rspData),
		.statusByte(statusByte), .devBusy(devBusy),
		.devSuspended(devSuspended), .supplyFault(supplyFault),
		.readMode(readMode), .powerdown_reset_n(powerdown_reset_n),
		.chipEnN(chipEnN), .outEnN(outEnN), .wrEnN(wrEnN),
		.addrOut(addrOut), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn),
		.ready_busy_out(ready_busy_out));
	flash_dev_model #(.MFR_ID(MFR), .DEV_ID(DEV)) flash_dev_model_inst (
		.ref_clk(ref_clk), .vppHigh(vppHigh),
		.powerdown_reset_n(powerdown_reset_n), .chipEnN(chipEnN),
		.outEnN(outEnN), .wrEnN(wrEnN), .addrOut(addrOut), .dqOut(dqOut),
		.dqIn(dqIn), .ready_busy_out(ready_busy_out));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task end_of_test();
		if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one user request, held until taken, answer kept in rErr and rDat
	task op(input logic [3:0] o, input logic [19:0] a, input logic [7:0] d);
		int n;
		cmdOp = o;
		cmdAddr = a;
		cmdData = d;
		cmdValid = 1'b1;
		n = 0;
		// ready is a state decode, so its level here holds at the next rise
		while (cmdReady !== 1'b1 && n < 100) begin
			@(negedge ref_clk);
			n++;
		end
		@(negedge ref_clk);
		cmdValid = 1'b0;
		while (rspValid !== 1'b1 && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
		rErr = rspErr;
		rDat = rspData;
		chk({7'h00, rspValid}, 8'h01);
	endtask : op
	// bounded wait for the device to finish or suspend
	task wait_for(input logic susp);
		int n;
		n = 0;
		while (devBusy !== 1'b0 && n < 1000) begin
			@(negedge ref_clk);
			n++;
		end
		chk({6'h00, devBusy, devSuspended}, {7'h00, susp});
	endtask : wait_for
	task t_wake();
		chk(statusByte, 8'h80);
		op(flash_host_pkg::OP_STATUS, 0, 0);
		chk({7'h00, rErr}, 8'h01); // still in wake guard
		repeat (45) @(negedge ref_clk);
		op(flash_host_pkg::OP_READ, 20'h00005, 0);
		chk(rDat, 8'hFF);
	endtask : t_wake
	task t_ident();
		op(flash_host_pkg::OP_IDENT, 0, 0);
		op(flash_host_pkg::OP_READ, 20'h00000, 0);
		chk(rDat, MFR);
		op(flash_host_pkg::OP_READ, 20'h00001, 0);
		chk(rDat, DEV);
		op(flash_host_pkg::OP_READ, 20'h00000, 0);
		chk(rDat, MFR);
		op(flash_host_pkg::OP_READ_ARRAY, 0, 0);
		op(flash_host_pkg::OP_READ, 20'h00000, 0);
		chk(rDat, 8'hFF);
	endtask : t_ident
	task t_write_erase();
		op(flash_host_pkg::OP_WRITE, 20'h00007, 8'hA5);
		wait_for(1'b0);
		op(flash_host_pkg::OP_WRITE, 20'h12345, 8'h3C);
		chk({6'h00, readMode}, 8'h03);
		op(flash_host_pkg::OP_READ_ARRAY, 0, 0);
		chk({7'h00, rErr}, 8'h01);
		wait_for(1'b0);
		op(flash_host_pkg::OP_STATUS, 0, 0);
		op(flash_host_pkg::OP_READ, 0, 0);
		chk(rDat, 8'h80);
		op(flash_host_pkg::OP_READ_ARRAY, 0, 0);
		op(flash_host_pkg::OP_READ, 20'h12345, 0);
		chk(rDat, 8'h3C);
		op(flash_host_pkg::OP_ERASE, 20'h12000, 0);
		op(flash_host_pkg::OP_SUSPEND, 0, 0);
		chk({7'h00, rErr}, 8'h00);
		wait_for(1'b1);
		op(flash_host_pkg::OP_STATUS, 0, 0);
		op(flash_host_pkg::OP_READ, 0, 0);
		chk(rDat, 8'hC0);
		op(flash_host_pkg::OP_CLEAR, 0, 0);
		chk({7'h00, rErr}, 8'h01);
		op(flash_host_pkg::OP_READ_ARRAY, 0, 0);
		op(flash_host_pkg::OP_READ, 20'h00007, 0);
		chk(rDat, 8'hA5);
		op(flash_host_pkg::OP_RESUME, 0, 0);
		op(flash_host_pkg::OP_STATUS, 0, 0);
		op(flash_host_pkg::OP_READ, 0, 0);
		chk(rDat, 8'h00);
		wait_for(1'b0);
		op(flash_host_pkg::OP_READ_ARRAY, 0, 0);
		op(flash_host_pkg::OP_READ, 20'h12345, 0);
		chk(rDat, 8'hFF);
	endtask : t_write_erase
	task t_supply();
		vppHigh = 1'b0;
		op(flash_host_pkg::OP_IDENT, 0, 0);
		op(flash_host_pkg::OP_READ, 20'h00001, 0);
		chk(rDat, DEV);
		op(flash_host_pkg::OP_ERASE, 20'h30000, 0);
		wait_for(1'b0);
		op(flash_host_pkg::OP_STATUS, 0, 0);
		op(flash_host_pkg::OP_READ, 0, 0);
		chk(rDat, 8'h88);
		op(flash_host_pkg::OP_WRITE, 20'h30001, 8'h00);
		chk({7'h00, rErr}, 8'h01);
		op(flash_host_pkg::OP_CLEAR, 0, 0);
		chk({7'h00, supplyFault}, 8'h00);
		op(flash_host_pkg::OP_STATUS, 0, 0);
		op(flash_host_pkg::OP_READ, 0, 0);
		chk(rDat, 8'h80);
		vppHigh = 1'b1;
	endtask : t_supply
	task t_reserved_pd();
		op(4'hA, 0, 0);
		chk({7'h00, rErr}, 8'h01);
		powerDownReq = 1'b1;
		repeat (3) @(negedge ref_clk);
		chk({7'h00, powerdown_reset_n}, 8'h00);
		powerDownReq = 1'b0;
		repeat (45) @(negedge ref_clk);
		op(flash_host_pkg::OP_READ, 20'h00007, 0);
		chk(rDat, 8'hA5);
		op(flash_host_pkg::OP_STATUS, 0, 0);
		op(flash_host_pkg::OP_READ, 0, 0);
		chk(rDat, 8'h80);
	endtask : t_reserved_pd
	// main sequence, inputs change on the falling edge
	initial begin
		{srst, cmdValid, powerDownReq, vppHigh} = 4'b1001;
		{cmdOp, cmdAddr, cmdData} = 32'h0000_0000;
		repeat (4) @(negedge ref_clk);
		srst = 1'b0;
		t_wake();
		t_ident();
		t_write_erase();
		t_supply();
		t_reserved_pd();
		end_of_test();
	end
	// hang guard, well past the expected one thousand or so cycles
	initial begin
		repeat (30000) @(posedge ref_clk);
		error_cnt++;
		end_of_test();
	end
endmodule : flash_host_ctrl_test
